// ==== shared/msoc_pkg.sv ====
// constants, register map and carriers of the measurement slot output block
package msoc_pkg;
    localparam logic [7:0] ADDR_OFFSET_HIGH  = 8'h2C;
    localparam logic [7:0] ADDR_VOLT_LOW     = 8'h2D;
    localparam logic [7:0] ADDR_CURR_LOW     = 8'h2E;
    localparam logic [7:0] ADDR_SPARE_LOW    = 8'h2F;
    localparam logic [7:0] ADDR_ENABLE_SEL   = 8'h31;
    localparam logic [7:0] ADDR_FORMAT       = 8'h40;
    localparam logic [7:0] ADDR_STATUS       = 8'h41;

    localparam logic [7:0] RST_OFFSET_HIGH   = 8'hCF;
    localparam logic [7:0] RST_OFFSET_LOW    = 8'hFF;
    localparam logic [7:0] RST_ENABLE_SEL    = 8'h00;
    localparam logic [7:0] RST_FORMAT        = 8'h0A;

    localparam int VOLT_HIGH_POS   = 6;
    localparam int CURR_HIGH_POS   = 4;
    localparam int SPARE_HIGH_POS  = 2;
    localparam int GROUP_SEL_POS   = 4;
    localparam int TDM_MODE_POS    = 4;
    localparam int RATE48_POS      = 5;
    localparam int VWLEN_POS       = 2;
    localparam int CWLEN_POS       = 0;
    localparam int SWLEN_POS       = 6;

    localparam logic [1:0] SEL_VOLT  = 2'h0;
    localparam logic [1:0] SEL_CURR  = 2'h1;
    localparam logic [1:0] SEL_SPARE = 2'h2;

    localparam int EN_VOLT  = 0;
    localparam int EN_CURR  = 1;
    localparam int EN_SPARE = 2;

    localparam logic [5:0] WLEN16 = 6'h10;
    localparam logic [5:0] WLEN20 = 6'h14;
    localparam logic [5:0] WLEN24 = 6'h18;
    localparam logic [5:0] WLEN32 = 6'h20;

    localparam int OFFSET_W = 10;
    localparam int CHANS    = 4;

    typedef struct packed {
        logic              active;
        logic [OFFSET_W-1:0] offset;
        logic [1:0]        wordLenCode;
    } msoc_group_cfg_s;

    typedef struct packed {
        logic        hit;
        logic [1:0]  chan;
        logic [4:0]  bitIdx;
    } msoc_slot_s;
endpackage

// ==== rtl/msoc_sync.sv ====
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module msoc_sync
    import msoc_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    input  wire logic din,
    output logic      dout
);
    logic stage1_r;
    logic stage2_r;
    logic stage1_nxt;
    logic stage2_nxt;

    always_comb begin
        stage1_nxt = stage1_r;
        stage2_nxt = stage2_r;
        if (ce) begin
            stage1_nxt = din;
            stage2_nxt = stage1_r;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stage1_r <= 1'b0;
            stage2_r <= 1'b0;
        end else begin
            stage1_r <= stage1_nxt;
            stage2_r <= stage2_nxt;
        end
    end

    assign dout = stage2_r;
endmodule
`default_nettype wire

// ==== rtl/msoc_group_slot.sv ====
// finds whether a frame bit falls in one group's four channel slots
`timescale 1ns/1ps
`default_nettype none
module msoc_group_slot
    import msoc_pkg::*;
(
    input  wire msoc_group_cfg_s cfg,
    input  wire logic [10:0]     bitPos,
    output msoc_slot_s           slot
);
    logic [5:0]  wordLen;
    logic [11:0] rel;
    logic [11:0] span;

    always_comb begin
        case (cfg.wordLenCode)
            2'h0:    wordLen = WLEN16;
            2'h1:    wordLen = WLEN20;
            2'h2:    wordLen = WLEN24;
            default: wordLen = WLEN32;
        endcase
        // signed-free compare: position before offset never hits
        rel  = {1'b0, bitPos} - {2'h0, cfg.offset};
        span = {6'h00, wordLen} << 2;
        slot.hit    = 1'b0;
        slot.chan   = 2'h0;
        slot.bitIdx = 5'h00;
        if (cfg.active && ({1'b0, bitPos} >= {2'h0, cfg.offset})
            && (rel < span)) begin
            slot.hit = 1'b1;
            if (rel < {6'h00, wordLen}) begin
                slot.chan   = 2'h0;
                slot.bitIdx = 5'(rel);
            end else if (rel < ({6'h00, wordLen} << 1)) begin
                slot.chan   = 2'h1;
                slot.bitIdx = 5'(rel - {6'h00, wordLen});
            end else if (rel < ({6'h00, wordLen} * 3)) begin
                slot.chan   = 2'h2;
                slot.bitIdx = 5'(rel - ({6'h00, wordLen} << 1));
            end else begin
                slot.chan   = 2'h3;
                slot.bitIdx = 5'(rel - ({6'h00, wordLen} * 3));
            end
        end
    end
endmodule
`default_nettype wire

// ==== rtl/msoc_slot_output.sv ====
// measurement slot placement and register file for the serial output
//
// Functional notes
// - non-TDM sends one group: 00 voltage, 01 current, 10 spare.
// - enable field 0000 sends no measurement data.
// - enable bit 0 sends voltage channels 1-4.
// - enable bit 1 sends current channels 1-4.
// - enable bit 2 sends spare channels 1-4.
// - voltage offset is high bits 7-6 plus its low register.
// - current offset is high bits 5-4 plus its low register.
// - spare offset is high bits 3-2 plus its low register.
// - offset counts bit clocks from frame start to group start.
// - offset linear, zero no delay, up to 1023 cycles.
// - voltage and spare offsets reset to maximum 1023.
// - current offset resets to 255.
// - enable and group select reset to zero.
// - non-TDM never sends current and voltage together.
// - word length code 00/01/10/11 gives 16/20/24/32 bits.
// - voltage data only sent at 48 kHz rate.
`timescale 1ns/1ps
`default_nettype none
module msoc_slot_output
    import msoc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic [7:0]  regAddr,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regWrStb,
    input  wire logic        regRdStb,
    output logic      [7:0]  regRdData,
    input  wire logic        bitClock,
    input  wire logic        frameClock,
    input  wire logic [31:0] voltageSample,
    input  wire logic [31:0] currentSample,
    input  wire logic [31:0] spareSample,
    output logic      [1:0]  sampleChan,
    output logic             serialMeasurementOutput,
    output logic             serialMeasurementOutputEn
);
    logic [7:0] offsetHigh_r;
    logic [7:0] voltLow_r;
    logic [7:0] currLow_r;
    logic [7:0] spareLow_r;
    logic [7:0] enableSel_r;
    logic [7:0] format_r;
    logic [7:0] rdData_r;
    logic [7:0] offsetHigh_nxt;
    logic [7:0] voltLow_nxt;
    logic [7:0] currLow_nxt;
    logic [7:0] spareLow_nxt;
    logic [7:0] enableSel_nxt;
    logic [7:0] format_nxt;
    logic [7:0] rdData_nxt;

    logic bitClockSync;
    logic frameClockSync;
    logic bitClockPrev_r;
    logic frameClockPrev_r;
    logic bitClockPrev_nxt;
    logic frameClockPrev_nxt;
    logic [10:0] bitPos_r;
    logic [10:0] bitPos_nxt;
    logic [10:0] curPos;
    logic        sdo_r;
    logic        sdoEn_r;
    logic [1:0]  chan_r;
    logic        sdo_nxt;
    logic        sdoEn_nxt;
    logic [1:0]  chan_nxt;

    logic [3:0]  txEnable;
    logic [1:0]  groupSel;
    logic        tdmMode;
    logic        rate48;
    logic        fallEdge;
    logic        frameStart;
    msoc_group_cfg_s voltCfg;
    msoc_group_cfg_s currCfg;
    msoc_group_cfg_s spareCfg;
    msoc_slot_s      voltSlot;
    msoc_slot_s      currSlot;
    msoc_slot_s      spareSlot;

    assign txEnable = enableSel_r[3:0];
    assign groupSel = enableSel_r[GROUP_SEL_POS +: 2];
    assign tdmMode  = format_r[TDM_MODE_POS];
    assign rate48   = format_r[RATE48_POS];

    // register file
    always_comb begin
        offsetHigh_nxt = offsetHigh_r;
        voltLow_nxt    = voltLow_r;
        currLow_nxt    = currLow_r;
        spareLow_nxt   = spareLow_r;
        enableSel_nxt  = enableSel_r;
        format_nxt     = format_r;
        rdData_nxt     = 8'h00;
        if (regWrStb) begin
            case (regAddr)
                ADDR_OFFSET_HIGH: offsetHigh_nxt = regWrData;
                ADDR_VOLT_LOW:    voltLow_nxt    = regWrData;
                ADDR_CURR_LOW:    currLow_nxt    = regWrData;
                ADDR_SPARE_LOW:   spareLow_nxt   = regWrData;
                ADDR_ENABLE_SEL:  enableSel_nxt  = regWrData;
                ADDR_FORMAT:      format_nxt     = regWrData;
                default:          ;
            endcase
        end
        if (regRdStb) begin
            case (regAddr)
                ADDR_OFFSET_HIGH: rdData_nxt = offsetHigh_r;
                ADDR_VOLT_LOW:    rdData_nxt = voltLow_r;
                ADDR_CURR_LOW:    rdData_nxt = currLow_r;
                ADDR_SPARE_LOW:   rdData_nxt = spareLow_r;
                ADDR_ENABLE_SEL:  rdData_nxt = enableSel_r;
                ADDR_FORMAT:      rdData_nxt = format_r;
                ADDR_STATUS:      rdData_nxt = {sdoEn_r, chan_r,
                                                bitPos_r[4:0]};
                default:          rdData_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            offsetHigh_r <= RST_OFFSET_HIGH;
            voltLow_r    <= RST_OFFSET_LOW;
            currLow_r    <= RST_OFFSET_LOW;
            spareLow_r   <= RST_OFFSET_LOW;
            enableSel_r  <= RST_ENABLE_SEL;
            format_r     <= RST_FORMAT;
            rdData_r     <= 8'h00;
        end else if (ce) begin
            offsetHigh_r <= offsetHigh_nxt;
            voltLow_r    <= voltLow_nxt;
            currLow_r    <= currLow_nxt;
            spareLow_r   <= spareLow_nxt;
            enableSel_r  <= enableSel_nxt;
            format_r     <= format_nxt;
            rdData_r     <= rdData_nxt;
        end
    end

    assign regRdData = rdData_r;

    // pin sampling
    msoc_sync u_bclkSync (
        .clk  (clk),
        .rst  (rst),
        .ce   (ce),
        .din  (bitClock),
        .dout (bitClockSync)
    );
    msoc_sync u_fsyncSync (
        .clk  (clk),
        .rst  (rst),
        .ce   (ce),
        .din  (frameClock),
        .dout (frameClockSync)
    );

    // group configuration
    always_comb begin
        voltCfg.offset  = {offsetHigh_r[VOLT_HIGH_POS +: 2], voltLow_r};
        currCfg.offset  = {offsetHigh_r[CURR_HIGH_POS +: 2], currLow_r};
        spareCfg.offset = {offsetHigh_r[SPARE_HIGH_POS +: 2],
                           spareLow_r};
        voltCfg.wordLenCode  = format_r[VWLEN_POS +: 2];
        currCfg.wordLenCode  = format_r[CWLEN_POS +: 2];
        spareCfg.wordLenCode = format_r[SWLEN_POS +: 2];
        if (tdmMode) begin
            // voltage exists only at the 48 kHz rate
            voltCfg.active  = txEnable[EN_VOLT] && rate48;
            currCfg.active  = txEnable[EN_CURR];
            spareCfg.active = txEnable[EN_SPARE];
        end else begin
            // one group only, so outputs never collide
            voltCfg.active  = (txEnable != 4'h0) && rate48
                              && (groupSel == SEL_VOLT);
            currCfg.active  = (txEnable != 4'h0)
                              && (groupSel == SEL_CURR);
            spareCfg.active = (txEnable != 4'h0)
                              && (groupSel == SEL_SPARE);
        end
    end

    msoc_group_slot u_voltSlot (
        .cfg    (voltCfg),
        .bitPos (curPos),
        .slot   (voltSlot)
    );
    msoc_group_slot u_currSlot (
        .cfg    (currCfg),
        .bitPos (curPos),
        .slot   (currSlot)
    );
    msoc_group_slot u_spareSlot (
        .cfg    (spareCfg),
        .bitPos (curPos),
        .slot   (spareSlot)
    );

    // frame bit counter and serialiser
    assign fallEdge   = bitClockPrev_r && !bitClockSync;
    assign frameStart = frameClockSync && !frameClockPrev_r;

    // slots look up the bit being launched, not the one just sent
    always_comb begin
        curPos = bitPos_r;
        // counter saturates so a missing frame edge stays silent
        if (frameStart) begin
            curPos = 11'h000;
        end else if (bitPos_r != 11'h7FF) begin
            curPos = bitPos_r + 11'h001;
        end
    end

    always_comb begin
        bitClockPrev_nxt   = bitClockSync;
        frameClockPrev_nxt = frameClockPrev_r;
        bitPos_nxt         = bitPos_r;
        sdo_nxt            = sdo_r;
        sdoEn_nxt          = sdoEn_r;
        chan_nxt           = chan_r;
        if (fallEdge) begin
            frameClockPrev_nxt = frameClockSync;
            bitPos_nxt         = curPos;
            sdo_nxt   = 1'b0;
            sdoEn_nxt = 1'b0;
            if (voltSlot.hit) begin
                sdoEn_nxt = 1'b1;
                chan_nxt  = voltSlot.chan;
                sdo_nxt   = voltageSample[5'h1F - voltSlot.bitIdx];
            end else if (currSlot.hit) begin
                sdoEn_nxt = 1'b1;
                chan_nxt  = currSlot.chan;
                sdo_nxt   = currentSample[5'h1F - currSlot.bitIdx];
            end else if (spareSlot.hit) begin
                sdoEn_nxt = 1'b1;
                chan_nxt  = spareSlot.chan;
                sdo_nxt   = spareSample[5'h1F - spareSlot.bitIdx];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bitClockPrev_r   <= 1'b0;
            frameClockPrev_r <= 1'b0;
            bitPos_r         <= 11'h7FF;
            sdo_r            <= 1'b0;
            sdoEn_r          <= 1'b0;
            chan_r           <= 2'h0;
        end else if (ce) begin
            bitClockPrev_r   <= bitClockPrev_nxt;
            frameClockPrev_r <= frameClockPrev_nxt;
            bitPos_r         <= bitPos_nxt;
            sdo_r            <= sdo_nxt;
            sdoEn_r          <= sdoEn_nxt;
            chan_r           <= chan_nxt;
        end
    end

    assign serialMeasurementOutput   = sdo_r;
    assign serialMeasurementOutputEn = sdoEn_r;
    assign sampleChan                = chan_r;
endmodule
`default_nettype wire

// ==== verif/msoc_host_model.sv ====
// host side model: drives bit and frame clocks, captures the serial line
`timescale 1ns/1ps
`default_nettype none
module msoc_host_model (
    output logic      bitClock,
    output logic      frameClock,
    input  wire logic       serialMeasurementOutput,
    input  wire logic       serialMeasurementOutputEn,
    input  wire logic [1:0] sampleChan
);
    logic       bitSeen  [0:2047];
    logic       enSeen   [0:2047];
    logic [1:0] chanSeen [0:2047];

    // bit clock stands still high between frames
    initial begin
        bitClock = 1'b1;
        frameClock = 1'b0;
    end

    task automatic frame(input int n);
        #3;
        for (int k = 0; k <= n; k++) begin
            #40 frameClock = (k == 0);
            #40 bitClock = 1'b0;
            // read the previous bit before the design reacts to this edge
            if (k > 0) begin
                bitSeen[k-1] = serialMeasurementOutput;
                enSeen[k-1] = serialMeasurementOutputEn;
                chanSeen[k-1] = sampleChan;
            end
            #80 bitClock = 1'b1;
        end
    endtask
endmodule
`default_nettype wire

// ==== verif/msoc_slot_output_props.sv ====
// port checks of the measurement slot output block
`timescale 1ns/1ps
`default_nettype none
module msoc_slot_output_props
    import msoc_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        ce,
    input wire logic [7:0]  regAddr,
    input wire logic [7:0]  regWrData,
    input wire logic        regWrStb,
    input wire logic        regRdStb,
    input wire logic [7:0]  regRdData,
    input wire logic        bitClock,
    input wire logic        frameClock,
    input wire logic [31:0] voltageSample,
    input wire logic [31:0] currentSample,
    input wire logic [31:0] spareSample,
    input wire logic [1:0]  sampleChan,
    input wire logic        serialMeasurementOutput,
    input wire logic        serialMeasurementOutputEn
);
    logic [7:0] enR;
    logic [7:0] fmtR;
    logic [7:0] voltLowR;
    logic       mapped;
    logic       quietV;
    logic       quietSel;

    always_ff @(posedge clk) begin
        if (rst) begin
            enR <= 8'h00;
            fmtR <= 8'h0A;
            voltLowR <= 8'hFF;
        end else if (ce && regWrStb) begin
            if (regAddr == ADDR_ENABLE_SEL) enR <= regWrData;
            if (regAddr == ADDR_FORMAT) fmtR <= regWrData;
            if (regAddr == ADDR_VOLT_LOW) voltLowR <= regWrData;
        end
    end
    assign mapped = regAddr inside {[8'h2C:8'h2F], 8'h31, 8'h40, 8'h41};
    assign quietV = enR[2:0] == 3'b001 && fmtR[4] && !fmtR[5];
    assign quietSel = !fmtR[4] && enR[5:4] == 2'b11;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_read_idle: assert property ($past(ce) && !$past(regRdStb)
        |-> regRdData == 8'h00) else $error("read data not idle");
    a_unmapped_zero: assert property ($past(ce && regRdStb && !mapped)
        |-> regRdData == 8'h00) else $error("unmapped read not zero");
    a_volt_readback: assert property (
        $past(ce && regRdStb && regAddr == ADDR_VOLT_LOW)
        |-> regRdData == $past(voltLowR)) else $error("voltage low bad");
    a_enable_readback: assert property (
        $past(ce && regRdStb && regAddr == ADDR_ENABLE_SEL)
        |-> regRdData == $past(enR)) else $error("enable read bad");
    a_enable_needed: assert property (
        $rose(serialMeasurementOutputEn)
        |-> enR[3:0] != 4'h0 || $past(enR[3:0] != 4'h0))
        else $error("output without enable");
    a_voltage_rate: assert property (
        $rose(serialMeasurementOutputEn) |-> !(quietV && $past(quietV)))
        else $error("voltage sent off rate");
    a_select_none: assert property (
        $rose(serialMeasurementOutputEn) |-> !(quietSel && $past(quietSel)))
        else $error("group sent on empty select");
    a_data_quiet: assert property (
        !serialMeasurementOutputEn |-> !serialMeasurementOutput)
        else $error("data on idle line");
    a_bits_stand: assert property (
        (bitClock == $past(bitClock)) [*6]
        |-> $stable(serialMeasurementOutput) && $stable(sampleChan)
        && $stable(serialMeasurementOutputEn)) else $error("bit moved");
endmodule
bind msoc_slot_output msoc_slot_output_props u_props (.*);
`default_nettype wire

// ==== verif/msoc_slot_output_test.sv ====
// self-checking bench of the measurement slot output block
`timescale 1ns/1ps
`default_nettype none
module msoc_slot_output_test;
    import msoc_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic [7:0]  regAddr = 8'h00;
    logic [7:0]  regWrData = 8'h00;
    logic        regWrStb = 1'b0;
    logic        regRdStb = 1'b0;
    logic [7:0]  regRdData;
    logic        bitClock;
    logic        frameClock;
    logic [31:0] voltageSample = 32'hA5C3_1E69;
    logic [31:0] currentSample = 32'h3C96_D24B;
    logic [31:0] spareSample = 32'hF00F_5AA5;
    logic [1:0]  sampleChan;
    logic        serialMeasurementOutput;
    logic        serialMeasurementOutputEn;
    int          error_cnt = 0;
    int          check_count = 0;
    int          cycles = 0;

    msoc_slot_output dut (.*);
    msoc_host_model host (.*);

    always #10 clk = ~clk;

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // generous ceiling, tests need about 26000 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 50000) begin
            error_cnt++;
            end_of_test();
        end
    end

    task automatic cmp(input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: want %h got %h", $time, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge clk);
        regWrStb <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge clk);
        regRdStb <= 1'b0;
        #1;
        cmp(exp, regRdData);
    endtask

    // one frame; expected bit per position from group offsets and lengths
    task automatic chk(input int n, input logic [2:0] m,
                       input int vo, co, so, vl, cl, sl);
        logic e;
        logic b;
        logic [1:0] c;
        host.frame(n);
        for (int p = 0; p < n; p++) begin
            e = 1'b0;
            b = 1'b0;
            c = 2'h0;
            if (m[0] && p >= vo && p < vo + 4 * vl) begin
                e = 1'b1;
                b = voltageSample[31 - (p - vo) % vl];
                c = 2'((p - vo) / vl);
            end else if (m[1] && p >= co && p < co + 4 * cl) begin
                e = 1'b1;
                b = currentSample[31 - (p - co) % cl];
                c = 2'((p - co) / cl);
            end else if (m[2] && p >= so && p < so + 4 * sl) begin
                e = 1'b1;
                b = spareSample[31 - (p - so) % sl];
                c = 2'((p - so) / sl);
            end
            cmp({6'h00, e, b}, {6'h00, host.enSeen[p], host.bitSeen[p]});
            if (e) begin
                cmp({6'h00, c}, {6'h00, host.chanSeen[p]});
            end
        end
    endtask

    task automatic t_regs;
        rd(ADDR_OFFSET_HIGH, 8'hCF);
        rd(ADDR_VOLT_LOW, 8'hFF);
        rd(ADDR_CURR_LOW, 8'hFF);
        rd(ADDR_SPARE_LOW, 8'hFF);
        rd(ADDR_ENABLE_SEL, 8'h00);
        rd(ADDR_FORMAT, RST_FORMAT);
        rd(8'h50, 8'h00);
        wr(ADDR_CURR_LOW, 8'h5A);
        rd(ADDR_CURR_LOW, 8'h5A);
        wr(8'h50, 8'hA5);
        rd(ADDR_ENABLE_SEL, 8'h00);
        $display("test registers done");
    endtask

    task automatic t_tdm;
        wr(ADDR_FORMAT, 8'h30);
        wr(ADDR_ENABLE_SEL, 8'h01);
        chk(1030, 3'b001, 1023, 0, 0, 16, 16, 16);
        wr(ADDR_OFFSET_HIGH, 8'h4B);
        wr(ADDR_VOLT_LOW, 8'h04);
        wr(ADDR_CURR_LOW, 8'h05);
        wr(ADDR_SPARE_LOW, 8'h8C);
        wr(ADDR_ENABLE_SEL, 8'h07);
        chk(720, 3'b111, 260, 5, 652, 16, 16, 16);
        $display("test tdm placement done");
    endtask

    task automatic t_wlen;
        int lens[4] = '{16, 20, 24, 32};
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_FORMAT, {6'b001100, c[1:0]});
            wr(ADDR_ENABLE_SEL, 8'h02);
            chk(4 * lens[c] + 10, 3'b010, 0, 5, 0, 0, lens[c], 0);
        end
        $display("test word length done");
    endtask

    task automatic t_quiet;
        wr(ADDR_ENABLE_SEL, 8'h00);
        chk(80, 3'b000, 0, 0, 0, 16, 16, 16);
        wr(ADDR_OFFSET_HIGH, 8'h0B);
        wr(ADDR_FORMAT, 8'h10);
        wr(ADDR_ENABLE_SEL, 8'h01);
        chk(80, 3'b000, 0, 0, 0, 16, 16, 16);
        $display("test quiet done");
    endtask

    task automatic t_nontdm;
        logic [2:0] msk;
        wr(ADDR_OFFSET_HIGH, 8'h03);
        wr(ADDR_FORMAT, 8'h20);
        for (int s = 0; s < 4; s++) begin
            wr(ADDR_ENABLE_SEL, {2'b00, s[1:0], 4'b0011});
            msk = (s == 3) ? 3'b000 : 3'(3'b001 << s);
            chk(210, msk, 4, 5, 140, 16, 16, 16);
        end
        $display("test non tdm done");
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_tdm();
        t_wlen();
        t_quiet();
        t_nontdm();
        end_of_test();
    end
endmodule
`default_nettype wire
